// >>> sciu_channel_irq.sv
// Purpose: interrupt enable, ranking and identification of one channel
// Assumes: channel strobes are one-cycle pulses on clk; 16x baud tick in
// Notes: registers on classic wishbone, ack one cycle after the request
`timescale 1ns/1ns
`default_nettype none

module sciu_channel_irq
  import sciu_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int FILL_W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic baud_tick16,
  input wire logic [FILL_W-1:0] rx_fill,
  input wire logic [FILL_W-1:0] tx_fill,
  input wire logic rx_char_stored,
  input wire logic rx_buffer_read,
  input wire logic tx_holding_write,
  input wire logic line_status_read,
  input wire logic modem_status_read,
  input wire logic overrun_event,
  input wire logic parity_error_flag,
  input wire logic framing_error_flag,
  input wire logic break_flag,
  input wire logic modem_change_event,
  output logic tx_holding_empty_flag,
  output logic channel_irq_output
);

  initial begin
    if (FILL_W < 5 || FIFO_DEPTH < 16 || FIFO_DEPTH >= (1 << FILL_W)) begin
      $error("sciu_channel_irq: fill width cannot hold fifo depth");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // bits per frame: start, data, parity, stop; one and a half rounds up
  function automatic logic [3:0] frame_bits(input logic [7:0] cfg);
    logic [3:0] n;
    n = 4'(SCIU_WL_BASE) + 4'(cfg[SCIU_CFG_WL_LO +: 2]);
    n = n + 4'(SCIU_FRAME_FIXED) + 4'(cfg[SCIU_CFG_STOP]);
    n = n + 4'(cfg[SCIU_CFG_PAR]);
    return n;
  endfunction

  function automatic logic [4:0] trig_level(input logic [1:0] code);
    logic [4:0] lvl;
    unique case (code)
      2'h0: lvl = SCIU_TRIG_0;
      2'h1: lvl = SCIU_TRIG_1;
      2'h2: lvl = SCIU_TRIG_2;
      2'h3: lvl = SCIU_TRIG_3;
    endcase
    return lvl;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register state

  logic [3:0] interrupt_enable_reg;
  logic [7:0] cfg_reg;
  logic fen_prev_reg;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic iir_read;
  logic [7:0] interrupt_identification;
  logic [7:0] status_view;
  logic fifo_enable_bit;
  logic [9:0] char_ticks;
  logic [9:0] timeout_ticks;
  logic [9:0] tx_delay_ticks;

  assign bus_req = wb_cyc && wb_stb && !wb_ack;
  assign bus_wr = bus_req && wb_we && wb_sel[0];
  assign bus_rd = bus_req && !wb_we;
  assign iir_read = bus_rd && (wb_adr == SCIU_ADR_IIR);
  assign fifo_enable_bit = cfg_reg[SCIU_CFG_FEN];

  // char time in ticks; stop bit time is one bit of ticks
  assign char_ticks = 10'(frame_bits(cfg_reg)) * 10'(SCIU_TICKS_PER_BIT);
  assign timeout_ticks = 10'(char_ticks * 10'(SCIU_TIMEOUT_CHARS));
  assign tx_delay_ticks = char_ticks - 10'(SCIU_TICKS_PER_BIT);

  always_ff @(posedge clk) begin
    if (rst) begin
      interrupt_enable_reg <= SCIU_IER_RESET;
    end else if (bus_wr && wb_adr == SCIU_ADR_IER) begin
      interrupt_enable_reg <= wb_dat_w[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= SCIU_CFG_RESET;
    end else if (bus_wr && wb_adr == SCIU_ADR_CFG) begin
      cfg_reg <= wb_dat_w[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fen_prev_reg <= 1'b0;
    end else begin
      fen_prev_reg <= fifo_enable_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive character timeout

  logic [9:0] tmo_cnt_reg;
  logic tmo_pend_reg;
  logic tmo_armed;

  // polled mode: timer held, nothing indicated
  assign tmo_armed = fifo_enable_bit && interrupt_enable_reg[SCIU_IER_RXD]
    && (rx_fill != '0);

  always_ff @(posedge clk) begin
    if (rst) begin
      tmo_cnt_reg <= '0;
      tmo_pend_reg <= 1'b0;
    end else if (rx_buffer_read) begin
      // read removes the idle condition, so the clear wins here
      tmo_cnt_reg <= '0;
      tmo_pend_reg <= 1'b0;
    end else if (!tmo_pend_reg) begin
      if (rx_char_stored || !tmo_armed) begin
        tmo_cnt_reg <= '0;
      end else if (baud_tick16) begin
        if (tmo_cnt_reg == timeout_ticks - 10'h001) begin
          tmo_pend_reg <= 1'b1;
          tmo_cnt_reg <= '0;
        end else begin
          tmo_cnt_reg <= tmo_cnt_reg + 10'h001;
        end
      end
    end else if (!tmo_armed) begin
      tmo_pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit empty indication with short-burst delay

  logic [1:0] tx_bytes_reg;
  logic tx_delaying_reg;
  logic [9:0] tx_dly_cnt_reg;
  logic tx_raw_empty;

  assign tx_raw_empty = (tx_fill == '0);

  // bytes seen in the fifo since the flag last went high, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_bytes_reg <= '0;
    end else if (!tx_holding_empty_flag && tx_raw_empty && !tx_delaying_reg
                 && tx_bytes_reg >= 2'(SCIU_MIN_TX_BYTES)) begin
      tx_bytes_reg <= '0;
    end else if (tx_delaying_reg && baud_tick16
                 && tx_dly_cnt_reg == tx_delay_ticks - 10'h001) begin
      tx_bytes_reg <= '0;
    end else if (tx_holding_write && tx_bytes_reg != 2'h3) begin
      tx_bytes_reg <= tx_bytes_reg + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_holding_empty_flag <= 1'b1;
      tx_delaying_reg <= 1'b0;
      tx_dly_cnt_reg <= '0;
    end else if (!tx_raw_empty || tx_holding_write) begin
      tx_holding_empty_flag <= 1'b0;
      tx_delaying_reg <= 1'b0;
      tx_dly_cnt_reg <= '0;
    end else if (!tx_holding_empty_flag && !tx_delaying_reg) begin
      if (tx_bytes_reg < 2'(SCIU_MIN_TX_BYTES)) begin
        tx_delaying_reg <= 1'b1;
      end else begin
        tx_holding_empty_flag <= 1'b1;
      end
    end else if (tx_delaying_reg && baud_tick16) begin
      if (tx_dly_cnt_reg == tx_delay_ticks - 10'h001) begin
        tx_holding_empty_flag <= 1'b1;
        tx_delaying_reg <= 1'b0;
        tx_dly_cnt_reg <= '0;
      end else begin
        tx_dly_cnt_reg <= tx_dly_cnt_reg + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky interrupt sources and the receive level source

  logic thr_pend_reg;
  logic thr_prev_reg;
  logic thr_set;
  logic thr_clr;
  logic lsr_pend_reg;
  logic lsr_set;
  logic msr_pend_reg;
  logic rxd_active;
  logic [3:0] id_code;

  always_ff @(posedge clk) begin
    if (rst) begin
      thr_prev_reg <= 1'b1;
    end else begin
      thr_prev_reg <= tx_holding_empty_flag;
    end
  end

  // edge of the empty flag, or any change of fifo enable
  assign thr_set = (tx_holding_empty_flag && !thr_prev_reg)
    || (fifo_enable_bit != fen_prev_reg);
  assign thr_clr = tx_holding_write
    || (iir_read && id_code == SCIU_ID_THR);

  always_ff @(posedge clk) begin
    if (rst) begin
      thr_pend_reg <= 1'b0;
    end else if (thr_set) begin
      thr_pend_reg <= 1'b1;
    end else if (thr_clr) begin
      thr_pend_reg <= 1'b0;
    end
  end

  assign lsr_set = overrun_event || parity_error_flag
    || framing_error_flag || break_flag;

  always_ff @(posedge clk) begin
    if (rst) begin
      lsr_pend_reg <= 1'b0;
    end else if (lsr_set) begin
      lsr_pend_reg <= 1'b1;
    end else if (line_status_read) begin
      lsr_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      msr_pend_reg <= 1'b0;
    end else if (modem_change_event) begin
      msr_pend_reg <= 1'b1;
    end else if (modem_status_read) begin
      msr_pend_reg <= 1'b0;
    end
  end

  // level source: trigger in fifo mode, any byte otherwise
  assign rxd_active = fifo_enable_bit
    ? (rx_fill >= FILL_W'(trig_level(cfg_reg[SCIU_CFG_TRIG_LO +: 2])))
    : (rx_fill != '0);

  ////////////////////////////////////////////////////////////////////////
  // ranking and identification

  always_comb begin
    id_code = SCIU_ID_NONE;
    if (lsr_pend_reg && interrupt_enable_reg[SCIU_IER_LSR]) begin
      id_code = SCIU_ID_LSR;
    end else if (rxd_active && interrupt_enable_reg[SCIU_IER_RXD]) begin
      id_code = SCIU_ID_RXD;
    end else if (tmo_pend_reg && fifo_enable_bit
                 && interrupt_enable_reg[SCIU_IER_RXD]) begin
      id_code = SCIU_ID_TMO;
    end else if (thr_pend_reg && interrupt_enable_reg[SCIU_IER_THR]) begin
      id_code = SCIU_ID_THR;
    end else if (msr_pend_reg && interrupt_enable_reg[SCIU_IER_MSR]) begin
      id_code = SCIU_ID_MSR;
    end
  end

  // bit 0 low means pending; only the winning code is shown
  assign interrupt_identification = {
    fifo_enable_bit ? SCIU_ID_FIFO_BITS : 2'h0,
    2'h0,
    id_code
  };

  assign status_view = {
    tmo_pend_reg, thr_pend_reg, lsr_pend_reg, msr_pend_reg,
    rxd_active, tx_delaying_reg, tx_holding_empty_flag, fifo_enable_bit
  };

  always_ff @(posedge clk) begin
    if (rst) begin
      channel_irq_output <= 1'b0;
    end else begin
      channel_irq_output <= !id_code[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack <= 1'b0;
    end else begin
      wb_ack <= bus_req;
    end
  end

  // unmapped addresses read zero and ignore writes, still acked
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_r <= '0;
    end else if (bus_rd) begin
      unique case (wb_adr)
        SCIU_ADR_IER: wb_dat_r <= {28'h000_0000, interrupt_enable_reg};
        SCIU_ADR_IIR: wb_dat_r <= {24'h00_0000, interrupt_identification};
        SCIU_ADR_CFG: wb_dat_r <= {24'h00_0000, cfg_reg};
        SCIU_ADR_STAT: wb_dat_r <= {24'h00_0000, status_view};
        default: wb_dat_r <= '0;
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> sciu_host_model.sv
// Purpose: host side model issuing classic wishbone cycles
// Assumes: one request at a time, held until done
// Notes: released address and data lines flip to show staleness
`timescale 1ns/1ns
`default_nettype none
module sciu_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic req_we,
  input wire logic [7:0] req_adr,
  input wire logic [7:0] req_dat,
  input wire logic wb_ack,
  input wire logic [31:0] wb_dat_r,
  output logic wb_cyc,
  output logic wb_stb,
  output logic wb_we,
  output logic [7:0] wb_adr,
  output logic [3:0] wb_sel,
  output logic [31:0] wb_dat_w,
  output logic done,
  output logic [7:0] rdat
);
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      wb_adr <= 8'h00;
      wb_sel <= 4'h0;
      wb_dat_w <= 32'h0000_0000;
      rdat <= 8'h00;
    end else if (wb_cyc) begin
      if (wb_ack) begin
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        done <= 1'b1;
        rdat <= wb_dat_r[7:0];
      end
    end else if (req && !done) begin
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= req_we;
      wb_adr <= req_adr;
      wb_sel <= 4'hF;
      wb_dat_w <= {24'h00_0000, req_dat};
    end else begin
      wb_adr <= ~wb_adr;
      wb_dat_w <= ~wb_dat_w;
    end
  end
endmodule
`default_nettype wire

// >>> sciu_pkg.sv
// Purpose: shared constants for the serial channel interrupt unit
// Assumes: classic wishbone, 32-bit data, one byte register per word
// Notes: printed offsets are indices; byte address is four times index
package sciu_pkg;

  // register indices and byte addresses
  localparam int SCIU_IDX_IER = 1;
  localparam int SCIU_IDX_IIR = 2;
  localparam int SCIU_IDX_CFG = 8;
  localparam int SCIU_IDX_STAT = 9;
  localparam logic [7:0] SCIU_ADR_IER = 8'(SCIU_IDX_IER * 4);
  localparam logic [7:0] SCIU_ADR_IIR = 8'(SCIU_IDX_IIR * 4);
  localparam logic [7:0] SCIU_ADR_CFG = 8'(SCIU_IDX_CFG * 4);
  localparam logic [7:0] SCIU_ADR_STAT = 8'(SCIU_IDX_STAT * 4);

  // interrupt enable fields
  localparam int SCIU_IER_RXD = 0;
  localparam int SCIU_IER_THR = 1;
  localparam int SCIU_IER_LSR = 2;
  localparam int SCIU_IER_MSR = 3;
  localparam logic [3:0] SCIU_IER_RESET = 4'h0;

  // config register fields
  localparam int SCIU_CFG_WL_LO = 0;
  localparam int SCIU_CFG_STOP = 2;
  localparam int SCIU_CFG_PAR = 3;
  localparam int SCIU_CFG_FEN = 4;
  localparam int SCIU_CFG_TRIG_LO = 6;
  localparam logic [7:0] SCIU_CFG_RESET = 8'h00;

  // identification codes, bits 3..0
  localparam logic [3:0] SCIU_ID_NONE = 4'h1;
  localparam logic [3:0] SCIU_ID_LSR = 4'h6;
  localparam logic [3:0] SCIU_ID_RXD = 4'h4;
  localparam logic [3:0] SCIU_ID_TMO = 4'hC;
  localparam logic [3:0] SCIU_ID_THR = 4'h2;
  localparam logic [3:0] SCIU_ID_MSR = 4'h0;
  localparam logic [1:0] SCIU_ID_FIFO_BITS = 2'h3;

  // receive trigger levels in bytes
  localparam logic [4:0] SCIU_TRIG_0 = 5'h01;
  localparam logic [4:0] SCIU_TRIG_1 = 5'h04;
  localparam logic [4:0] SCIU_TRIG_2 = 5'h08;
  localparam logic [4:0] SCIU_TRIG_3 = 5'h0E;

  // timing and frame sizes; bit time in internal ticks, timeout in chars, tx minimum in bytes
  localparam int SCIU_TICKS_PER_BIT = 16;
  localparam int SCIU_TIMEOUT_CHARS = 4;
  localparam int SCIU_MIN_TX_BYTES = 2;
  localparam int SCIU_WL_BASE = 5;
  localparam int SCIU_FRAME_FIXED = 2;

endpackage

// >>> sciu_props.sv
// Purpose: port checker for the channel interrupt unit
// Assumes: enable and config copies follow acked writes
// Notes: copies may lag the design a cycle; checks allow for it
`timescale 1ns/1ns
`default_nettype none
module sciu_props
  import sciu_pkg::*;
#(
  parameter int FILL_W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  input wire logic [31:0] wb_dat_r,
  input wire logic wb_ack,
  input wire logic baud_tick16,
  input wire logic [FILL_W-1:0] rx_fill,
  input wire logic [FILL_W-1:0] tx_fill,
  input wire logic rx_char_stored,
  input wire logic rx_buffer_read,
  input wire logic tx_holding_write,
  input wire logic line_status_read,
  input wire logic modem_status_read,
  input wire logic overrun_event,
  input wire logic parity_error_flag,
  input wire logic framing_error_flag,
  input wire logic break_flag,
  input wire logic modem_change_event,
  input wire logic tx_holding_empty_flag,
  input wire logic channel_irq_output
);
  logic [3:0] ier_q;
  logic [7:0] cfg_q;
  logic line_q;
  logic [4:0] lvl;
  wire logic take = wb_cyc && wb_stb && !wb_ack;
  wire logic rd_iir = take && !wb_we && wb_adr == SCIU_ADR_IIR;
  wire logic rd_ier = take && !wb_we && wb_adr == SCIU_ADR_IER;
  wire logic wr_ok = wb_ack && wb_we && wb_sel[0];
  wire logic fen = cfg_q[SCIU_CFG_FEN];
  wire logic line_ev = overrun_event | parity_error_flag |
    framing_error_flag | break_flag;
  assign lvl = cfg_q[7] ? (cfg_q[6] ? SCIU_TRIG_3 : SCIU_TRIG_2) :
    (cfg_q[6] ? SCIU_TRIG_1 : SCIU_TRIG_0);
  always_ff @(posedge clk) begin
    if (rst) begin
      ier_q <= 4'h0;
      cfg_q <= 8'h00;
    end else if (wr_ok && wb_adr == SCIU_ADR_IER) begin
      ier_q <= wb_dat_w[3:0];
    end else if (wr_ok && wb_adr == SCIU_ADR_CFG) begin
      cfg_q <= wb_dat_w[7:0];
    end
  end
  // set wins over the clearing read, as in the design
  always_ff @(posedge clk) begin
    if (rst) begin
      line_q <= 1'b0;
    end else if (line_ev) begin
      line_q <= 1'b1;
    end else if (line_status_read) begin
      line_q <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_ack_next:
    assert property (take |=> wb_ack) else $error("no ack");
  chk_ack_pulse:
    assert property (wb_ack |=> !wb_ack) else $error("ack too long");
  chk_ier_read:
    assert property (rd_ier |=> wb_dat_r[7:0] == {4'h0, ier_q})
    else $error("enable readback wrong");
  chk_iir_fixed:
    assert property (rd_iir |=> wb_dat_r[5:4] == 2'h0 &&
      wb_dat_r[7:6] == {2{fen}} && (fen || !wb_dat_r[3]))
    else $error("id fixed bits wrong");
  chk_iir_off:
    assert property ((rd_iir && ier_q == 4'h0) |=>
      wb_dat_r[3:0] == SCIU_ID_NONE) else $error("id not inhibited");
  chk_irq_off:
    assert property ((ier_q == 4'h0) [*2] |-> !channel_irq_output)
    else $error("irq while all disabled");
  chk_line_irq:
    assert property ((line_ev && ier_q[2] && !wb_cyc) |->
      ##2 channel_irq_output) else $error("line irq missing");
  chk_tx_on_fen:
    assert property ((wr_ok && wb_adr == SCIU_ADR_CFG && ier_q[1] &&
      wb_dat_w[SCIU_CFG_FEN] != fen) |-> ##[1:3] channel_irq_output)
    else $error("no tx irq after fifo enable change");
  chk_rx_level:
    assert property ((fen && ier_q[0] && rx_fill >= FILL_W'(lvl)) [*3]
      |-> channel_irq_output) else $error("trigger irq missing");
  chk_line_first:
    assert property ((rd_iir && line_q && ier_q[2] &&
      !line_status_read) |=> wb_dat_r[3:0] == SCIU_ID_LSR)
    else $error("line status not ranked first");
  cov_line: cover property (rd_iir && line_q && ier_q[2]);
  cov_fen: cover property (wr_ok && wb_adr == SCIU_ADR_CFG && ier_q[1]);
  cov_irq: cover property ($rose(channel_irq_output));
endmodule
bind sciu_channel_irq sciu_props #(.FILL_W(FILL_W)) i_sciu_props (.*);
`default_nettype wire

// >>> testbench.sv
// Purpose: self-checking bench for the channel interrupt unit
// Assumes: frame of 7 bits (5 data, 1 stop, no parity)
// Notes: char time 112 ticks, timeout 448, tx delay 96
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sciu_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic req_we = 1'b0;
  logic [7:0] req_adr = 8'h00;
  logic [7:0] req_dat = 8'h00;
  logic wb_cyc, wb_stb, wb_we, wb_ack, done;
  logic [7:0] wb_adr, rdat;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic baud_tick16 = 1'b0;
  logic [4:0] rx_fill = 5'h00;
  logic [4:0] tx_fill = 5'h00;
  logic rx_char_stored = 1'b0, rx_buffer_read = 1'b0;
  logic tx_holding_write = 1'b0, line_status_read = 1'b0;
  logic modem_status_read = 1'b0, overrun_event = 1'b0;
  logic parity_error_flag = 1'b0, framing_error_flag = 1'b0;
  logic break_flag = 1'b0, modem_change_event = 1'b0;
  logic tx_holding_empty_flag, channel_irq_output;
  logic [31:0] lfsr = 32'h0000_22A6;
  logic [7:0] cfg_v = 8'h00;
  int failures = 0;
  int checked = 0;
  int cyc_n = 0;
  sciu_channel_irq i_sciu_channel_irq (.*);
  sciu_host_model i_sciu_host_model (.*);
  always #2 clk = ~clk;
  //////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [4:0] trig(input int k);
    return (k == 0) ? 5'h01 : (k == 1) ? 5'h04 : (k == 2) ? 5'h08 : 5'h0E;
  endfunction
  task automatic conclude;
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a,
      input logic [7:0] d);
    req <= 1'b1;
    req_we <= we;
    req_adr <= a;
    req_dat <= d;
    do @(posedge clk); while (done !== 1'b1);
    req <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rdat, e);
  endtask
  // one bit per channel strobe, overrun in bit 0, modem change in bit 9
  task automatic setv(input logic [9:0] m);
    {modem_change_event, modem_status_read, line_status_read,
      tx_holding_write, rx_buffer_read, rx_char_stored, break_flag,
      framing_error_flag, parity_error_flag, overrun_event} <= m;
  endtask
  task automatic pulse(input logic [9:0] m);
    setv(m);
    @(posedge clk);
    setv(10'h000);
    repeat (2) @(posedge clk);
  endtask
  task automatic ticks(input int n);
    baud_tick16 <= 1'b1;
    repeat (n) @(posedge clk);
    baud_tick16 <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(SCIU_ADR_IER, 8'h00);
    rd(SCIU_ADR_IIR, 8'h01);
    bus(1'b1, SCIU_ADR_IER, 8'hFF);
    rd(SCIU_ADR_IER, 8'h0F);
    rd(8'h3C, 8'h00);
    bus(1'b1, SCIU_ADR_IER, 8'h00);
    rx_fill <= 5'h0E;
    bus(1'b1, SCIU_ADR_CFG, 8'hD0);
    rd(SCIU_ADR_IIR, 8'hC1);
    bus(1'b1, SCIU_ADR_IER, 8'h01);
    for (int k = 0; k < 4; k++) begin
      rx_fill <= trig(k) - 5'h01;
      bus(1'b1, SCIU_ADR_CFG, {k[1:0], 6'h10});
      rd(SCIU_ADR_IIR, 8'hC1);
      rx_fill <= trig(k);
      rd(SCIU_ADR_IIR, 8'hC4);
      chk({7'h00, channel_irq_output}, 8'h01);
    end
    rx_fill <= 5'h01;
    pulse(10'h010);
    ticks(400);
    pulse(10'h010);
    ticks(400);
    rd(SCIU_ADR_IIR, 8'hC1);
    ticks(60);
    rd(SCIU_ADR_IIR, 8'hCC);
    pulse(10'h020);
    rd(SCIU_ADR_IIR, 8'hC1);
    bus(1'b1, SCIU_ADR_CFG, 8'h00);
    ticks(500);
    rd(SCIU_ADR_IIR, 8'h04);
    bus(1'b1, SCIU_ADR_CFG, 8'h10);
    bus(1'b1, SCIU_ADR_IER, 8'h0F);
    for (int k = 0; k < 4; k++) begin
      pulse(10'h200 | (10'h001 << k));
      rd(SCIU_ADR_IIR, 8'hC6);
      pulse(10'h080);
      rd(SCIU_ADR_IIR, 8'hC4);
    end
    rx_fill <= 5'h00;
    rd(SCIU_ADR_IIR, 8'hC2);
    rd(SCIU_ADR_IIR, 8'hC0);
    pulse(10'h100);
    rd(SCIU_ADR_IIR, 8'hC1);
    bus(1'b1, SCIU_ADR_IER, 8'h02);
    tx_fill <= 5'h01; // one byte only per service
    pulse(10'h040);
    chk({7'h00, channel_irq_output}, 8'h00);
    tx_fill <= 5'h00;
    ticks(80);
    chk({7'h00, tx_holding_empty_flag}, 8'h00);
    ticks(30);
    chk({7'h00, tx_holding_empty_flag}, 8'h01);
    chk({7'h00, channel_irq_output}, 8'h01);
    for (int r = 0; r < 4; r++) begin
      lfsr = nxt(lfsr);
      bus(1'b1, SCIU_ADR_IER, lfsr[7:0]);
      cfg_v = lfsr[15:8];
      bus(1'b1, SCIU_ADR_CFG, cfg_v);
      for (int i = 0; i < 500; i++) begin
        lfsr = nxt(lfsr);
        setv(lfsr[9:0] & {10{lfsr[31:29] == 3'h0}});
        rx_fill <= {1'b0, lfsr[15:12]};
        tx_fill <= {1'b0, lfsr[19:16]};
        baud_tick16 <= lfsr[20];
        @(posedge clk);
      end
      setv(10'h000);
      baud_tick16 <= 1'b0;
      repeat (3) @(posedge clk);
      bus(1'b0, SCIU_ADR_IIR, 8'h00);
      chk(rdat & 8'hF0, {{2{cfg_v[SCIU_CFG_FEN]}}, 6'h00});
    end
    conclude();
  end
endmodule
`default_nettype wire
